// *** src/cwos_pkg.sv ***
// constants and types shared by the configuration word option block
package cwos_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POWERUP_HOLD_TIMER_DELAY_MS = 96;
  localparam int unsigned POWERUP_HOLD_TIMER_CYCLES = (POWERUP_HOLD_TIMER_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned OST_TOSC_PERIODS = 1024;
  localparam int unsigned OST_CYCLES = OST_TOSC_PERIODS;  // one device clock per oscillator period
  localparam int unsigned WDT_BASE_TICKS = 64;
  localparam logic [3:0] WDT_SHIFT_PS01 = 4'h0;
  localparam logic [3:0] WDT_SHIFT_PS10 = 4'h4;
  localparam logic [3:0] WDT_SHIFT_PS11 = 4'h8;
  localparam logic [15:0] TMR_OVF_VALUE = 16'hffff;  // wraps after 65536 periods

  // ----------------------------------------------------------------
  // configuration address map and layout
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_LOW_BASE = 16'hfe00;
  localparam logic [15:0] CFG_HIGH_BASE = 16'hfe08;
  localparam logic [15:0] CFG_LAST = 16'hfe0f;
  localparam logic [15:0] CFG_CELLS_RESET = 16'hffff;  // blank part, all unprogrammed
  localparam logic [15:0] CFG_IMPL_MASK = 16'hc05f;    // eight real cells
  localparam logic [7:0] TBL_HIGH_FILL = 8'hff;
  localparam int unsigned POS_OSC0 = 0;
  localparam int unsigned POS_WDT0 = 2;
  localparam int unsigned POS_PM0 = 4;
  localparam int unsigned POS_PM1 = 6;
  localparam int unsigned POS_BOD = 14;
  localparam int unsigned POS_PM2 = 15;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CWOS_PM_MICROPROC = 3'b111,
    CWOS_PM_MICROCTL = 3'b110,
    CWOS_PM_EXTENDED = 3'b101,
    CWOS_PM_CODE_PROT = 3'b000
  } cwos_mode_e;

  typedef enum logic [1:0] {
    CWOS_OSC_EXTERNAL_CLOCK_IN = 2'b11,
    CWOS_OSC_CRYSTAL_RESONATOR = 2'b10,
    CWOS_OSC_RC = 2'b01,
    CWOS_OSC_LOWPOWER_CRYSTAL = 2'b00
  } cwos_osc_e;

  localparam logic [1:0] WDT_CODE_OFF = 2'b00;

endpackage : cwos_pkg

// *** src/cwos_hold_timer.sv ***
// reload-and-count-down hold timer used for start-up delays
`timescale 1ns/10ps
module cwos_hold_timer #(
  parameter int unsigned CYCLES = 1024,
  parameter bit RUN_AT_RESET = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic start,
  // status
  output logic busy
);

  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] IDLE = '0;

  logic [W-1:0] remain;

  // a reset loads the full count so the hold begins at release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      remain <= RUN_AT_RESET ? LOAD : IDLE;
    end else if (start) begin
      remain <= LOAD;
    end else if (remain != IDLE) begin
      remain <= remain - W'(1);
    end
  end

  assign busy = (remain != IDLE);

endmodule : cwos_hold_timer

// *** src/cwos_config.sv ***
// configuration word cells, table access, option latches, start-up timers, watchdog and sleep
`timescale 1ns/10ps
module cwos_config
  import cwos_pkg::*;
#(
  parameter int unsigned POWERUP_HOLD_TIMER_HOLD_CYCLES = POWERUP_HOLD_TIMER_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pins from outside the clock domain
  input wire logic master_clear_prog_pin,
  input wire logic prog_voltage_pin,
  input wire logic wdt_osc_clk,
  // table access from the core
  input wire logic table_read_instr,
  input wire logic table_write_instr,
  input wire logic [15:0] table_addr,
  output logic [7:0] table_latch_low,
  output logic [7:0] table_latch_high,
  output logic table_read_done,
  // core events
  input wire logic brownout_reset,
  input wire logic sleep_instr,
  input wire logic clear_wdt_instr,
  input wire logic enabled_irq,
  // option controls
  output logic [2:0] opt_proc_mode,
  output logic opt_brownout_detect_enable,
  output logic [1:0] opt_watchdog_scale,
  output logic [1:0] opt_osc_select,
  // device state
  output logic device_reset,
  output logic asleep,
  output logic timeout_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_cfg_range(input logic [15:0] a);
    in_cfg_range = (a >= CFG_LOW_BASE) && (a <= CFG_LAST);
  endfunction : in_cfg_range

  function automatic logic [3:0] wdt_shift(input logic [1:0] code);
    unique case (code)
      2'b11: wdt_shift = WDT_SHIFT_PS11;
      2'b10: wdt_shift = WDT_SHIFT_PS10;
      2'b01: wdt_shift = WDT_SHIFT_PS01;
      2'b00: wdt_shift = WDT_SHIFT_PS01;
    endcase
  endfunction : wdt_shift

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] mclr_sync;
  logic [1:0] vpp_sync;
  logic [2:0] wdt_osc_sync;

  // two stages before any logic; wdt clock keeps a third for edge detect
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mclr_sync <= 2'h3;
      vpp_sync <= 2'h0;
      wdt_osc_sync <= 3'h0;
    end else begin
      mclr_sync <= {mclr_sync[0], master_clear_prog_pin};
      vpp_sync <= {vpp_sync[0], prog_voltage_pin};
      wdt_osc_sync <= {wdt_osc_sync[1:0], wdt_osc_clk};
    end
  end

  logic ext_reset;
  logic prog_volt;
  logic wdt_tick;
  assign ext_reset = !mclr_sync[1];
  assign prog_volt = vpp_sync[1] && mclr_sync[1];
  assign wdt_tick = wdt_osc_sync[1] && !wdt_osc_sync[2];

  // ----------------------------------------------------------------
  // configuration cells
  // ----------------------------------------------------------------
  logic [15:0] cells;
  logic cfg_hit;
  logic cfg_write;
  assign cfg_hit = in_cfg_range(table_addr);
  assign cfg_write = table_write_instr && cfg_hit && prog_volt;

  // one-time cells: a write only ever clears a bit, the data is ignored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cells <= CFG_CELLS_RESET;
    end else if (cfg_write && CFG_IMPL_MASK[table_addr[3:0]]) begin
      cells[table_addr[3:0]] <= 1'b0;
    end
  end

  logic [7:0] low_byte;
  logic [7:0] high_byte;
  // unimplemented positions read as ones
  assign low_byte = cells[7:0] | ~CFG_IMPL_MASK[7:0];
  assign high_byte = cells[15:8] | ~CFG_IMPL_MASK[15:8];

  // ----------------------------------------------------------------
  // table read path
  // ----------------------------------------------------------------
  cwos_mode_e live_mode;
  logic mode_maps_cfg;
  logic cfg_read;
  assign live_mode = cwos_mode_e'({cells[POS_PM2], cells[POS_PM1], cells[POS_PM0]});
  assign mode_maps_cfg = (live_mode == CWOS_PM_MICROCTL) || (live_mode == CWOS_PM_CODE_PROT);
  assign cfg_read = table_read_instr && cfg_hit && (mode_maps_cfg || prog_volt);

  // latches change only on a served read; other addresses belong to program memory
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      table_latch_low <= 8'h00;
      table_latch_high <= 8'h00;
      table_read_done <= 1'b0;
    end else begin
      table_read_done <= cfg_read;
      if (cfg_read) begin
        table_latch_low <= table_addr[3] ? high_byte : low_byte;
        table_latch_high <= TBL_HIGH_FILL;
      end
    end
  end

  // ----------------------------------------------------------------
  // start-up timers and reset hold
  // ----------------------------------------------------------------
  logic powerup_hold_timer_busy;
  logic ost_busy;
  logic ost_start;
  logic hold;
  logic wake_irq;
  logic wdt_fire;
  logic crystal_mode;

  assign crystal_mode = (opt_osc_select == CWOS_OSC_CRYSTAL_RESONATOR) ||
                        (opt_osc_select == CWOS_OSC_LOWPOWER_CRYSTAL);
  // brown-out restarts the oscillator wait; power-up is covered by the reset load
  assign ost_start = (brownout_reset && opt_brownout_detect_enable) ||
                     (asleep && wake_irq && crystal_mode);

  // power-up delay only runs from the power-on reset itself
  cwos_hold_timer #(.CYCLES(POWERUP_HOLD_TIMER_HOLD_CYCLES), .RUN_AT_RESET(1'b1)) u_powerup_hold_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(1'b0),
    .busy(powerup_hold_timer_busy)
  );

  cwos_hold_timer #(.CYCLES(OST_CYCLES), .RUN_AT_RESET(1'b1)) u_ost (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(ost_start),
    .busy(ost_busy)
  );

  assign hold = powerup_hold_timer_busy || ost_busy || ext_reset;

  // options follow the cells only while the device is held in reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opt_proc_mode <= 3'h7;
      opt_brownout_detect_enable <= 1'b1;
      opt_watchdog_scale <= 2'h3;
      opt_osc_select <= 2'h3;
    end else if (hold) begin
      opt_proc_mode <= live_mode;
      opt_brownout_detect_enable <= cells[POS_BOD];
      opt_watchdog_scale <= cells[POS_WDT0 +: 2];
      opt_osc_select <= cells[POS_OSC0 +: 2];
    end
  end

  // ----------------------------------------------------------------
  // watchdog and plain timer
  // ----------------------------------------------------------------
  logic wdt_on;
  logic [15:0] wdt_cnt;
  logic [15:0] wdt_limit;
  logic [15:0] tmr_cnt;
  logic tmr_ovf;
  logic wdt_clear;
  assign wdt_on = (opt_watchdog_scale != WDT_CODE_OFF);
  assign wdt_limit = 16'(WDT_BASE_TICKS) << wdt_shift(opt_watchdog_scale);
  assign wdt_clear = hold || sleep_instr || clear_wdt_instr || (asleep && wake_irq);
  assign wdt_fire = wdt_on && wdt_tick && (wdt_cnt == wdt_limit - 16'h1) && !wdt_clear;
  assign tmr_ovf = !wdt_on && !asleep && !hold && (tmr_cnt == TMR_OVF_VALUE);

  // watchdog counts its own oscillator ticks, so it keeps running in sleep
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wdt_cnt <= 16'h0;
    end else if (wdt_clear || wdt_fire) begin
      wdt_cnt <= 16'h0;
    end else if (wdt_on && wdt_tick) begin
      wdt_cnt <= wdt_cnt + 16'h1;
    end
  end

  // plain timer on device clock; frozen while asleep
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tmr_cnt <= 16'h0;
    end else if (hold || wdt_on || clear_wdt_instr) begin
      tmr_cnt <= 16'h0;
    end else if (!asleep) begin
      tmr_cnt <= tmr_cnt + 16'h1;
    end
  end

  // overflow or time-out clears the flag; overflow wins over a same-cycle set, which masks a time-out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timeout_flag <= 1'b1;
    end else if (tmr_ovf || wdt_fire) begin
      timeout_flag <= 1'b0;
    end else if (clear_wdt_instr || sleep_instr) begin
      timeout_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sleep and device reset
  // ----------------------------------------------------------------
  assign wake_irq = enabled_irq;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      asleep <= 1'b0;
    end else if (ext_reset || wdt_fire || wake_irq || hold) begin
      asleep <= 1'b0;
    end else if (sleep_instr) begin
      asleep <= 1'b1;
    end
  end

  // a watchdog reset is a pulse; it does not wait for the next hold
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      device_reset <= 1'b1;
    end else begin
      device_reset <= hold || wdt_fire;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  high_latch_fill_a: assert property (table_read_done |-> table_latch_high == TBL_HIGH_FILL)
    else $error("high latch not all ones after config read");
  low_byte_read_a: assert property (cfg_read && !table_addr[3] |=> table_latch_low == $past(low_byte))
    else $error("low config byte not loaded");
  high_byte_read_a: assert property (cfg_read && table_addr[3] |=> table_latch_low == $past(high_byte))
    else $error("high config byte not loaded");
  any_data_write_a: assert property (cfg_write && CFG_IMPL_MASK[table_addr[3:0]]
                                     |=> cells[$past(table_addr[3:0])] == 1'b0)
    else $error("write did not program cell");
  no_vpp_write_a: assert property (!prog_volt |=> $stable(cells))
    else $error("cell changed without programming voltage");
  mode_gate_a: assert property (table_read_instr && cfg_hit && !prog_volt && !mode_maps_cfg
                                |=> !table_read_done)
    else $error("config read served in wrong mode");
  prog_read_a: assert property (table_read_instr && cfg_hit && prog_volt |=> table_read_done)
    else $error("programmer read not served");
  opts_frozen_a: assert property (!hold && !$past(hold) |-> $stable(opt_watchdog_scale) && $stable(opt_proc_mode))
    else $error("options changed outside reset");
  wdt_off_reset_a: assert property (!wdt_on |=> !wdt_fire ##1 (device_reset == $past(hold)))
    else $error("watchdog reset while disabled");
  timer_ovf_a: assert property (tmr_ovf |=> !timeout_flag && !device_reset)
    else $error("timer overflow misbehaved");
  irq_wake_a: assert property (asleep && wake_irq |=> !asleep)
    else $error("interrupt did not wake");
  ost_wake_a: assert property (asleep && wake_irq && crystal_mode |=> ost_busy [*8])
    else $error("start-up hold missing after wake");

  cov_cfg_read_c: cover property (cfg_read && table_addr[3]);
  cov_prog_write_c: cover property (cfg_write ##[1:20] cfg_read);
  cov_sleep_wake_c: cover property (sleep_instr ##[1:50] (asleep && wake_irq));

endmodule : cwos_config

// *** sim/cwos_programmer.sv ***
// device programmer model: raises programming voltage and writes cells in ascending order
`timescale 1ns/10ps
module cwos_programmer (
  // clock
  input wire logic clk_sys,
  // control from the bench
  input wire logic start,
  input wire logic [15:0] prog_mask,
  input wire logic keep_volt,
  // pins toward the device
  output logic prog_voltage_pin,
  output logic table_write_instr,
  output logic [15:0] table_addr,
  output logic busy
);
  initial begin
    busy = 1'b0;
    table_write_instr = 1'b0;
    table_addr = 16'hfe00;
    forever begin
      @(posedge clk_sys);
      if (start) begin
        busy <= 1'b1;
        // the device synchronises the voltage, so give it time before writing
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 16; i++) begin
          table_addr <= 16'hfe00 + 16'(i);
          table_write_instr <= prog_mask[i];
          @(posedge clk_sys);
        end
        table_write_instr <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
  // write alone never programs, so voltage stays up through the whole pass
  assign prog_voltage_pin = busy | keep_volt;
endmodule : cwos_programmer

// *** sim/cwos_config_test.sv ***
// self-checking bench for the configuration word option block
`timescale 1ns/10ps
module cwos_config_test;
  import cwos_pkg::*;
  localparam int POWERUP_HOLD_TIMER_SIM = 1500;
  localparam logic [2:0] MODES [4] = '{CWOS_PM_MICROPROC, CWOS_PM_MICROCTL, CWOS_PM_EXTENDED, CWOS_PM_CODE_PROT};
  localparam logic [1:0] OSCS [4] = '{CWOS_OSC_EXTERNAL_CLOCK_IN, CWOS_OSC_CRYSTAL_RESONATOR, CWOS_OSC_RC,
    CWOS_OSC_LOWPOWER_CRYSTAL};
  localparam logic [1:0] WDTS [4] = '{2'h1, 2'h2, 2'h3, WDT_CODE_OFF};
  logic clk_sys = 1'b0, rst_n = 1'b0, mclr = 1'b1, wosc = 1'b0, rd_i = 1'b0, tb_wr = 1'b0;
  logic bo = 1'b0, sl = 1'b0, cw = 1'b0, irq = 1'b0, p_start = 1'b0, keep_volt = 1'b0;
  logic [15:0] tb_addr = 16'hfe00, p_mask = 16'h0000, p_addr, w;
  logic [7:0] tl_lo, tl_hi;
  logic [2:0] o_pm;
  logic [1:0] o_wd, o_osc;
  logic done, o_bod, dev_rst, slp, to_flag, p_wr, p_busy, pv;
  logic [31:0] seed = 32'h249afc0b;
  int errors = 0, total_checks = 0, cyc = 0, rel, n, rst_hits = 0, rst_base = 0;

  // ----------------------------------------------------------------
  // clocks, design and programmer
  // ----------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;
  always #30 wosc = ~wosc;  // six system clocks per watchdog tick
  always @(posedge clk_sys) cyc <= cyc + 1;
  // counts reset cycles so a one-cycle watchdog pulse is measured, not just seen
  always @(posedge clk_sys) if (dev_rst === 1'b1) rst_hits <= rst_hits + 1;

  cwos_config #(.POWERUP_HOLD_TIMER_HOLD_CYCLES(POWERUP_HOLD_TIMER_SIM)) cwos_config_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .master_clear_prog_pin(mclr), .prog_voltage_pin(pv),
    .wdt_osc_clk(wosc), .table_read_instr(rd_i), .table_write_instr(p_wr | tb_wr),
    .table_addr(p_busy ? p_addr : tb_addr), .table_latch_low(tl_lo), .table_latch_high(tl_hi),
    .table_read_done(done), .brownout_reset(bo), .sleep_instr(sl), .clear_wdt_instr(cw),
    .enabled_irq(irq), .opt_proc_mode(o_pm), .opt_brownout_detect_enable(o_bod),
    .opt_watchdog_scale(o_wd), .opt_osc_select(o_osc), .device_reset(dev_rst), .asleep(slp),
    .timeout_flag(to_flag));

  cwos_programmer cwos_programmer_inst (
    .clk_sys(clk_sys), .start(p_start), .prog_mask(p_mask), .keep_volt(keep_volt),
    .prog_voltage_pin(pv), .table_write_instr(p_wr), .table_addr(p_addr), .busy(p_busy));

  // ----------------------------------------------------------------
  // expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] cfg_byte(input logic [15:0] v, input logic hi);
    logic [15:0] r;
    r = v | ~CFG_IMPL_MASK;  // unimplemented cells always read as ones
    return hi ? r[15:8] : r[7:0];
  endfunction : cfg_byte

  function automatic logic mapped(input logic [15:0] v);
    return {v[15], v[6], v[4]} == CWOS_PM_MICROCTL || {v[15], v[6], v[4]} == CWOS_PM_CODE_PROT;
  endfunction : mapped

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    total_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %0t %s took %0d cycles, allowed %0d to %0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  // a served read pulses done once within the sampled window
  task automatic rd(input logic [15:0] a, input logic ok, input logic [7:0] exp);
    int d;
    d = 0;
    @(posedge clk_sys);
    rd_i <= 1'b1;
    tb_addr <= a;
    @(posedge clk_sys);
    rd_i <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      #1;
      d += (done === 1'b1);
      @(posedge clk_sys);
    end
    chk(16'(d), 16'(ok), "read served count");
    if (ok) chk({tl_hi, tl_lo}, {8'hff, exp}, "table latches");
  endtask : rd

  task automatic wr(input logic [15:0] a);
    @(posedge clk_sys);
    tb_wr <= 1'b1;
    tb_addr <= a;
    @(posedge clk_sys);
    tb_wr <= 1'b0;
  endtask : wr

  task automatic wait_low(input int lim);
    n = 0;
    while (dev_rst !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_low

  task automatic wait_to(input int lim);
    n = 0;
    while (to_flag === 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_to

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // one power-on round per mode, oscillator and watchdog code
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = seed[15:0];  // random reserved bits: writes to them must be ignored
      {w[15], w[6], w[4]} = MODES[i];
      w[3:0] = {WDTS[i], OSCS[i]};
      @(posedge clk_sys);
      rst_n <= 1'b0;
      tick(5);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      rel = cyc;
      wr(16'hfe0e);
      @(posedge clk_sys);
      p_start <= 1'b1;
      p_mask <= ~w;
      @(posedge clk_sys);
      p_start <= 1'b0;
      tick(25);
      rd(16'hfe00, mapped(w), cfg_byte(w, 1'b0));
      keep_volt <= 1'b1;
      tick(3);
      rd(16'hfe00 | 16'(seed[18:16]), 1'b1, cfg_byte(w, 1'b0));
      rd(16'hfe08 | 16'(seed[21:19]), 1'b1, cfg_byte(w, 1'b1));
      wait_low(3000);
      chk_rng(cyc - rel, POWERUP_HOLD_TIMER_SIM - 3, POWERUP_HOLD_TIMER_SIM + 5, "power-up hold");
      chk(16'(o_pm), 16'(MODES[i]), "mode option");
      chk(16'(o_wd), 16'(WDTS[i]), "watchdog option");
      chk(16'(o_osc), 16'(OSCS[i]), "oscillator option");
      chk(16'(o_bod), 16'(w[14]), "brown-out option");
      wr(16'hfe0e);
      tick(2);
      chk(16'(o_bod), 16'(w[14]), "frozen option");
      rd(16'hfe08, 1'b1, cfg_byte(w & 16'hbfff, 1'b1));
      keep_volt <= 1'b0;
      @(posedge clk_sys);
      bo <= 1'b1;
      @(posedge clk_sys);
      bo <= 1'b0;
      tick(3);
      n = 0;
      while (dev_rst === 1'b1 && n < 3000) begin
        tick(1);
        n++;
      end
      if (w[14]) chk_rng(n, 1016, 1026, "brown-out hold");
      else chk(16'(n), 16'h0000, "brown-out ignored");
      @(posedge clk_sys);
      cw <= 1'b1;
      @(posedge clk_sys);
      cw <= 1'b0;
      rst_base = rst_hits;
      wait_to(WDTS[i] == WDT_CODE_OFF ? 70000 : 1000);
      // the reset pulse is counted one edge after the flag drops, so let that edge pass
      tick(1);
      if (WDTS[i] == 2'h1) chk_rng(n, 372, 396, "watchdog fire");
      if (WDTS[i] == 2'h1) chk(16'(rst_hits - rst_base), 16'h0001, "watchdog reset");
      if (WDTS[i][1]) chk(16'(to_flag), 16'h0001, "long postscale");
      if (WDTS[i] == WDT_CODE_OFF) chk_rng(n, 65528, 65542, "plain timer");
      if (WDTS[i] == WDT_CODE_OFF) chk(16'(rst_hits - rst_base), 16'h0000, "no watchdog reset");
      @(posedge clk_sys);
      sl <= 1'b1;
      @(posedge clk_sys);
      sl <= 1'b0;
      tick(1);
      chk(16'({slp, to_flag}), 16'h0003, "sleep entry");
      @(posedge clk_sys);
      if (i == 2) mclr <= 1'b0;
      else irq <= 1'b1;
      tick(5);
      chk(16'(slp), 16'h0000, "wake");
      // pins change on the rising edge only
      @(posedge clk_sys);
      mclr <= 1'b1;
      irq <= 1'b0;
      n = 0;
      while (dev_rst === 1'b1 && n < 3000) begin
        tick(1);
        n++;
      end
      if (i != 2 && !OSCS[i][0]) chk_rng(n, 1014, 1026, "wake hold");
      if (i != 2 && OSCS[i][0]) chk(16'(n), 16'h0000, "no wake hold");
      $display("round %0d done", i);
    end
    close_out();
  end

  // a hang counts as a mismatch
  initial begin
    #1500000;
    errors++;
    $display("[ERR] %0t run did not finish", $time);
    close_out();
  end
endmodule : cwos_config_test
